// file: src/ldp_pkg.sv
// Package of constants and types for the LED channel dimming PWM block.
// Assumes a 25 MHz system clock and a same-clock register write/read port.
package ldp_pkg;

  // --------------------------------------------------------------------
  // Sizes and timing
  // --------------------------------------------------------------------
  localparam int unsigned LDP_CHANNELS = 12;
  localparam int unsigned LDP_LEVEL_W = 7;
  localparam int unsigned LDP_CLK_HZ = 25_000_000;
  localparam int unsigned LDP_CLK_PERIOD_NS = 1_000_000_000 / LDP_CLK_HZ;
  localparam int unsigned LDP_RES_NS = 400;
  localparam int unsigned LDP_TICK_CYCLES = LDP_RES_NS / LDP_CLK_PERIOD_NS;
  localparam int unsigned LDP_OPEN_US = 10;
  // Longer than 10 us means strictly more cycles than this count.
  localparam int unsigned LDP_OPEN_CYCLES = (LDP_OPEN_US * 1000 + LDP_CLK_PERIOD_NS - 1)
                                            / LDP_CLK_PERIOD_NS;
  localparam int unsigned LDP_RES_PER_S = 1_000_000_000 / LDP_RES_NS;
  localparam int unsigned LDP_FREQ_HZ0 = 150;
  localparam int unsigned LDP_FREQ_HZ1 = 300;
  localparam int unsigned LDP_FREQ_HZ2 = 600;
  localparam int unsigned LDP_FREQ_HZ3 = 1200;
  localparam int unsigned LDP_PER_W = 15;
  localparam logic [LDP_PER_W-1:0] LDP_PER0 = LDP_PER_W'(LDP_RES_PER_S / LDP_FREQ_HZ0);
  localparam logic [LDP_PER_W-1:0] LDP_PER1 = LDP_PER_W'(LDP_RES_PER_S / LDP_FREQ_HZ1);
  localparam logic [LDP_PER_W-1:0] LDP_PER2 = LDP_PER_W'(LDP_RES_PER_S / LDP_FREQ_HZ2);
  localparam logic [LDP_PER_W-1:0] LDP_PER3 = LDP_PER_W'(LDP_RES_PER_S / LDP_FREQ_HZ3);

  // --------------------------------------------------------------------
  // Duty mapping: fraction of a period in Q16, 65536 is fully on
  // --------------------------------------------------------------------
  localparam int unsigned LDP_FRAC_ONE = 65536;
  localparam int unsigned LDP_ALPHA_NUM = 9471;
  localparam int unsigned LDP_ALPHA_DEN = 10000;
  localparam int unsigned LDP_LEVEL_MAX = 127;

  // --------------------------------------------------------------------
  // Register field positions and reset values
  // --------------------------------------------------------------------
  localparam int unsigned LDP_GLOBAL_EN_BIT = 12;
  localparam int unsigned LDP_LIN_BIT = 2;
  localparam int unsigned LDP_FREQ_LSB = 0;
  localparam logic [15:0] LDP_FAULT_RST = 16'h0000;
  localparam logic [6:0] LDP_LEVEL_RST = 7'h00;
  localparam logic [11:0] LDP_BITS_RST = 12'h000;
  localparam logic [7:0] LDP_CONF_RST = 8'h00;

  // Register targets of the write port, one-hot coded.
  typedef enum logic [4:0] {
    LDP_SEL_COMMON_LEVEL = 5'b00001,
    LDP_SEL_CHANNEL_LEVEL = 5'b00010,
    LDP_SEL_DIM_ENABLE = 5'b00100,
    LDP_SEL_DIM_CONFIG = 5'b01000,
    LDP_SEL_CHANNEL_CONF = 5'b10000
  } ldp_sel_t;

  // One register write request from the bus decoder.
  typedef struct packed {
    ldp_sel_t sel;
    logic [3:0] chan;
    logic [15:0] data;
  } ldp_wreq_t;

endpackage : ldp_pkg

// file: src/ldp_dimming_pwm.sv
// Twelve-channel LED dimming PWM with per-channel fault flags.
// Assumes the serial bus decoder runs on the same clock and issues register
// writes and fault-register reads as one-cycle strobes; open-load inputs are
// asynchronous and are synchronised here.
`timescale 1ns/10ps
module ldp_dimming_pwm (
  input wire logic clock, // System clock, 25 MHz.
  input wire logic rstn, // Asynchronous reset, active low.
  input wire logic wr_strobe, // One-cycle register write strobe.
  input ldp_pkg::ldp_wreq_t wr_req, // Write target, channel and data.
  input wire logic fault_rd_strobe, // One-cycle read of the fault register.
  input wire logic [ldp_pkg::LDP_CHANNELS-1:0] open_load_in, // Raw open-load levels.
  output logic [15:0] fault_rdata, // Fault register value captured on read.
  output logic fault_rvalid, // Pulse marking fault_rdata valid.
  output logic [ldp_pkg::LDP_CHANNELS-1:0] output_channel // Channel on/off drive.
);
  import ldp_pkg::*;

  // --------------------------------------------------------------------
  // Mapping tables
  // --------------------------------------------------------------------

  // Builds the Q16 fraction table for log or linear mapping.
  function automatic logic [16:0] frac_of(input int unsigned lvl, input logic lin);
    longint unsigned f;
    f = LDP_FRAC_ONE;
    if (lin) begin
      f = (longint'(lvl) * LDP_FRAC_ONE + LDP_LEVEL_MAX / 2) / LDP_LEVEL_MAX;
    end else if (lvl == 0) begin
      f = 0;
    end else begin
      for (int unsigned k = lvl; k < LDP_LEVEL_MAX; k++) begin
        f = (f * LDP_ALPHA_NUM + LDP_ALPHA_DEN / 2) / LDP_ALPHA_DEN;
      end
    end
    return f[16:0];
  endfunction : frac_of

  logic [16:0] log_tab [0:127];
  logic [16:0] lin_tab [0:127];
  // Constant lookup tables, filled once by the mapping function.
  always_comb begin
    for (int unsigned i = 0; i < 128; i++) begin
      log_tab[i] = frac_of(i, 1'b0);
      lin_tab[i] = frac_of(i, 1'b1);
    end
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  logic [6:0] chan_level_r [LDP_CHANNELS];
  logic [11:0] dim_enable_bits_r;
  logic [11:0] channel_on_off_bits_r;
  logic global_dim_enable_r;
  logic linear_mapping_select_r;
  logic [1:0] freq_sel_r;
  logic [11:0] fault_r;
  logic [15:0] fault_rdata_r;
  logic fault_rvalid_r;
  logic [11:0] out_r;

  // Enable, static configuration and mapping registers.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      dim_enable_bits_r <= LDP_BITS_RST;
      channel_on_off_bits_r <= LDP_BITS_RST;
      global_dim_enable_r <= 1'b0;
      linear_mapping_select_r <= LDP_CONF_RST[LDP_LIN_BIT];
      freq_sel_r <= LDP_CONF_RST[LDP_FREQ_LSB +: 2];
    end else if (wr_strobe) begin
      unique case (wr_req.sel)
        LDP_SEL_DIM_ENABLE: begin
          dim_enable_bits_r <= wr_req.data[11:0];
        end
        LDP_SEL_CHANNEL_CONF: begin
          channel_on_off_bits_r <= wr_req.data[11:0];
          global_dim_enable_r <= wr_req.data[LDP_GLOBAL_EN_BIT];
        end
        LDP_SEL_DIM_CONFIG: begin
          linear_mapping_select_r <= wr_req.data[LDP_LIN_BIT];
          freq_sel_r <= wr_req.data[LDP_FREQ_LSB +: 2];
        end
        default: begin
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Period timebase in 400 ns ticks
  // --------------------------------------------------------------------
  logic [3:0] tick_cnt_r;
  logic [LDP_PER_W-1:0] phase_r;
  logic [LDP_PER_W-1:0] period;
  logic tick;

  // Period length for the selected frequency.
  always_comb begin
    unique case (freq_sel_r)
      2'b00: period = LDP_PER0;
      2'b01: period = LDP_PER1;
      2'b10: period = LDP_PER2;
      2'b11: period = LDP_PER3;
    endcase
  end

  assign tick = (tick_cnt_r == 4'(LDP_TICK_CYCLES - 1));

  // Tick prescaler and phase counter; phase restarts at the next tick if the period shrinks to or below it.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_r <= 4'h0;
      phase_r <= '0;
    end else begin
      tick_cnt_r <= tick ? 4'h0 : tick_cnt_r + 4'h1;
      if (tick) begin
        phase_r <= (phase_r >= period - 1'b1) ? '0 : phase_r + 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------
  // Per-channel logic
  // --------------------------------------------------------------------
  for (genvar c = 0; c < LDP_CHANNELS; c++) begin : g_chan
    logic [1:0] ol_sync_r;
    logic [7:0] ol_cnt_r;
    logic [16:0] frac;
    logic [31:0] width_full;
    logic [LDP_PER_W:0] width;
    logic pwm_on;

    // Channel level: own write or copy of a common level write.
    // The write-only common level needs no register of its own: it lives on in the copies.
    always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
        chan_level_r[c] <= LDP_LEVEL_RST;
      end else if (wr_strobe && wr_req.sel == LDP_SEL_COMMON_LEVEL) begin
        chan_level_r[c] <= wr_req.data[6:0];
      end else if (wr_strobe && wr_req.sel == LDP_SEL_CHANNEL_LEVEL &&
                   wr_req.chan == 4'(c)) begin
        chan_level_r[c] <= wr_req.data[6:0];
      end
    end

    // High time in ticks, rounded to the nearest 400 ns step.
    assign frac = linear_mapping_select_r ? lin_tab[chan_level_r[c]]
                                          : log_tab[chan_level_r[c]];
    assign width_full = 32'(period) * 32'(frac) + 32'h0000_8000;
    assign width = width_full[16 +: LDP_PER_W+1];
    // Level 127 gives the full period and level 0 gives zero width.
    assign pwm_on = ({1'b0, phase_r} < width);

    // Output selection between PWM and static drive.
    always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
        out_r[c] <= 1'b0;
      end else if (dim_enable_bits_r[c] && global_dim_enable_r) begin
        out_r[c] <= pwm_on;
      end else begin
        out_r[c] <= channel_on_off_bits_r[c];
      end
    end

    // Two-flop synchroniser for the open-load level.
    always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
        ol_sync_r <= 2'b00;
      end else begin
        ol_sync_r <= {ol_sync_r[0], open_load_in[c]};
      end
    end

    // Duration counter; saturates once the open load exceeds 10 us.
    always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
        ol_cnt_r <= 8'h00;
      end else if (!ol_sync_r[1]) begin
        ol_cnt_r <= 8'h00;
      end else if (ol_cnt_r <= 8'(LDP_OPEN_CYCLES)) begin
        ol_cnt_r <= ol_cnt_r + 8'h01;
      end
    end

    // Sticky fault bit; a set in the read cycle wins over the clear.
    always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
        fault_r[c] <= LDP_FAULT_RST[c];
      end else if (ol_cnt_r > 8'(LDP_OPEN_CYCLES)) begin
        fault_r[c] <= 1'b1;
      end else if (fault_rd_strobe) begin
        fault_r[c] <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Fault register read
  // --------------------------------------------------------------------

  // Captures the fault flags on a read; upper bits read as zero.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      fault_rdata_r <= LDP_FAULT_RST;
      fault_rvalid_r <= 1'b0;
    end else begin
      fault_rvalid_r <= fault_rd_strobe;
      if (fault_rd_strobe) begin
        fault_rdata_r <= {4'h0, fault_r};
      end
    end
  end

  // Outputs come straight from their registers.
  assign fault_rdata = fault_rdata_r;
  assign fault_rvalid = fault_rvalid_r;
  assign output_channel = out_r;

endmodule : ldp_dimming_pwm

// file: tb/ldp_assertions.sv
// Port checker for the LED dimming PWM block.
// Assumes it is bound into ldp_dimming_pwm and shares its clock and reset.
`timescale 1ns/10ps
module ldp_assertions (
  input wire logic clock, // System clock.
  input wire logic rstn, // Reset, active low.
  input wire logic wr_strobe, // Write strobe.
  input ldp_pkg::ldp_wreq_t wr_req, // Write request.
  input wire logic fault_rd_strobe, // Fault read strobe.
  input wire logic [ldp_pkg::LDP_CHANNELS-1:0] open_load_in, // Open-load levels.
  input wire logic [15:0] fault_rdata, // Fault read data.
  input wire logic fault_rvalid, // Fault read valid.
  input wire logic [ldp_pkg::LDP_CHANNELS-1:0] output_channel // Channel drive.
);
  import ldp_pkg::*;
  logic [11:0] den_r;
  logic [11:0] st_r;
  logic glb_r;
  logic full_r;
  logic zero_r;
  logic [8:0] hi_cnt_r;
  wire logic [11:0] pm = den_r & {12{glb_r}}; // Channels on the PWM path.
  // Shadows enables, static bits and whether all levels are 127 or 0.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      den_r <= 12'h000;
      st_r <= 12'h000;
      glb_r <= 1'b0;
      full_r <= 1'b0;
      zero_r <= 1'b1;
    end else if (wr_strobe) begin
      if (wr_req.sel == LDP_SEL_DIM_ENABLE) den_r <= wr_req.data[11:0];
      if (wr_req.sel == LDP_SEL_CHANNEL_CONF) {glb_r, st_r} <= wr_req.data[12:0];
      if (wr_req.sel[1:0] != 2'b00) begin
        full_r <= wr_req.sel[0] && wr_req.data[6:0] == 7'h7f;
        zero_r <= wr_req.sel[0] && wr_req.data[6:0] == 7'h00;
      end
    end
  end
  // Counts how long channel 0 has been held in open load.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) hi_cnt_r <= 9'h000;
    else if (!open_load_in[0]) hi_cnt_r <= 9'h000;
    else if (hi_cnt_r != 9'h1ff) hi_cnt_r <= hi_cnt_r + 9'h001;
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);
  sequence quiet_reads_s;
    (open_load_in == 12'h000)[*4] ##0 fault_rd_strobe ##[1:3] fault_rd_strobe;
  endsequence
  sequence settled_s;
    (!wr_strobe)[*3];
  endsequence
  read_answer_a: assert property (fault_rd_strobe |=> fault_rvalid)
    else $error("no read answer");
  answer_only_a: assert property (!fault_rd_strobe |=> !fault_rvalid)
    else $error("read answer without request");
  upper_zero_a: assert property (fault_rvalid |-> fault_rdata[15:12] == 4'h0)
    else $error("fault data upper bits set");
  rdata_hold_a: assert property (!fault_rvalid |-> $stable(fault_rdata))
    else $error("fault data changed without read");
  read_clears_a: assert property (quiet_reads_s |=> fault_rdata == 16'h0000)
    else $error("fault flags not cleared by read");
  fault_sets_a: assert property (
    fault_rd_strobe && hi_cnt_r > 9'h104 |=> fault_rdata[0])
    else $error("long open load not flagged");
  static_path_a: assert property (
    settled_s |-> ((output_channel ^ st_r) & ~pm) == 12'h000)
    else $error("static channel wrong");
  full_on_a: assert property (
    settled_s |-> !full_r || (output_channel & pm) == pm)
    else $error("level 127 not fully on");
  full_off_a: assert property (
    settled_s |-> !zero_r || (output_channel & pm) == 12'h000)
    else $error("level 0 not off");
endmodule : ldp_assertions

// file: tb/ldp_host_model.sv
// Host model issuing register writes and fault reads to the block.
// Assumes the block samples its strobes on the rising clock edge.
`timescale 1ns/10ps
module ldp_host_model (
  input wire logic clock, // System clock.
  output logic wr_strobe, // Write strobe.
  output ldp_pkg::ldp_wreq_t wr_req, // Write request.
  output logic fault_rd_strobe, // Fault read strobe.
  input wire logic fault_rvalid, // Fault read valid.
  input wire logic [15:0] fault_rdata // Fault read data.
);
  import ldp_pkg::*;
  logic autorecovery_on = 1'b0; // This host never runs autorecovery.
  // Idle bus at time zero.
  initial begin
    wr_strobe = 1'b0;
    wr_req = '0;
    fault_rd_strobe = 1'b0;
  end
  // One-cycle write; zero levels are withheld while autorecovery runs.
  task automatic put(input ldp_sel_t sel, input logic [3:0] chan, input logic [15:0] data);
    if (autorecovery_on && sel[1:0] != 2'b00 && data[6:0] == 7'h00) return;
    @(posedge clock);
    wr_strobe <= 1'b1;
    wr_req <= {sel, chan, data};
    @(posedge clock);
    wr_strobe <= 1'b0;
  endtask : put
  // Sends all twelve channel levels one after another as twelve separate channel level writes.
  task automatic bulk(input logic [83:0] lv);
    for (int i = 0; i < 12; i++) begin
      put(LDP_SEL_CHANNEL_LEVEL, 4'(i), {9'h000, lv[i*7 +: 7]});
    end
  endtask : bulk
  // One-cycle fault read; the answer is taken in the following cycle.
  task automatic get(output logic [15:0] data);
    @(posedge clock);
    fault_rd_strobe <= 1'b1;
    @(posedge clock);
    fault_rd_strobe <= 1'b0;
    #1;
    data = fault_rvalid ? fault_rdata : 16'hxxxx;
  endtask : get
endmodule : ldp_host_model

// file: tb/tb.sv
// Self-checking bench for the LED dimming PWM block.
// Assumes the host model drives the write port and the checker is bound in.
`timescale 1ns/10ps
module tb;
  import ldp_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic wr_strobe;
  logic fault_rd_strobe;
  logic fault_rvalid;
  ldp_wreq_t wr_req;
  logic [11:0] open_load_in = 12'h000;
  logic [15:0] fault_rdata;
  logic [11:0] output_channel;
  logic [15:0] rd;
  int bad_count = 0;
  int samples_checked = 0;
  // Clock of 40 ns period.
  always #20 clock = ~clock;
  // Block and its bus host.
  ldp_dimming_pwm ldp_dimming_pwm_inst (.clock(clock), .rstn(rstn), .wr_strobe(wr_strobe),
    .wr_req(wr_req), .fault_rd_strobe(fault_rd_strobe), .open_load_in(open_load_in),
    .fault_rdata(fault_rdata), .fault_rvalid(fault_rvalid), .output_channel(output_channel));
  ldp_host_model ldp_host_model_inst (.clock(clock), .wr_strobe(wr_strobe), .wr_req(wr_req),
    .fault_rd_strobe(fault_rd_strobe), .fault_rvalid(fault_rvalid), .fault_rdata(fault_rdata));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  task automatic wr(input ldp_sel_t sel, input logic [3:0] ch, input logic [15:0] d);
    ldp_host_model_inst.put(sel, ch, d);
  endtask : wr
  // Lets a write reach the outputs.
  task automatic settle;
    repeat (3) @(posedge clock);
    #1;
  endtask : settle
  // Waits a bounded time for a channel level; running out ends the run.
  task automatic wait_for(input int ch, input logic v, input int lim);
    for (int i = 0; i <= lim; i++) begin
      @(posedge clock);
      #1;
      if (output_channel[ch] === v) return;
    end
    bad_count++;
    end_of_test();
  endtask : wait_for
  // Measures one high pulse in clock cycles.
  task automatic high_time(input int ch, input int lim, output logic [15:0] hi);
    wait_for(ch, 1'b0, lim);
    wait_for(ch, 1'b1, lim);
    hi = 16'h0000;
    while (output_channel[ch] === 1'b1 && hi < 16'hffff) begin
      @(posedge clock);
      #1;
      hi++;
    end
    // A pulse that never ends is a hang and closes the run.
    if (hi == 16'hffff) begin
      bad_count++;
      end_of_test();
    end
  endtask : high_time
  // Accepts a pulse width within one 400 ns step of the expected one.
  function automatic logic [15:0] near(input int seen, input int exp);
    return (seen >= exp - 10 && seen <= exp + 10) ? 16'(exp) : 16'(seen);
  endfunction : near
  // Short open load is ignored, long one latches, reads clear.
  task automatic t_fault;
    @(posedge clock);
    open_load_in <= 12'h008;
    repeat (240) @(posedge clock);
    open_load_in <= 12'h801;
    repeat (300) @(posedge clock);
    ldp_host_model_inst.get(rd);
    check(rd, 16'h0801);
    @(posedge clock);
    open_load_in <= 12'h000;
    repeat (5) @(posedge clock);
    ldp_host_model_inst.get(rd);
    check(rd, 16'h0801);
    ldp_host_model_inst.get(rd);
    check(rd, 16'h0000);
    $display("fault test done");
  endtask : t_fault
  // Static on/off, global enable and full levels.
  task automatic t_full;
    wr(LDP_SEL_CHANNEL_CONF, 4'h0, 16'h0a5c);
    settle();
    check({4'h0, output_channel}, 16'h0a5c);
    wr(LDP_SEL_DIM_ENABLE, 4'h0, 16'h00ff);
    wr(LDP_SEL_CHANNEL_CONF, 4'h0, 16'h1a00);
    wr(LDP_SEL_COMMON_LEVEL, 4'h0, 16'h007f);
    settle();
    check({4'h0, output_channel}, 16'h0aff);
    wr(LDP_SEL_CHANNEL_CONF, 4'h0, 16'h0a00);
    settle();
    check({4'h0, output_channel}, 16'h0a00);
    wr(LDP_SEL_CHANNEL_CONF, 4'h0, 16'h1a00);
    settle();
    check({4'h0, output_channel}, 16'h0aff);
    wr(LDP_SEL_COMMON_LEVEL, 4'h0, 16'h0000);
    settle();
    check({4'h0, output_channel}, 16'h0a00);
    $display("level test done");
  endtask : t_full
  // Channel levels, both mappings and two frequencies.
  task automatic t_duty;
    logic [15:0] hi;
    int exp;
    wr(LDP_SEL_DIM_ENABLE, 4'h0, 16'h0fff);
    wr(LDP_SEL_CHANNEL_CONF, 4'h0, 16'h1000);
    ldp_host_model_inst.bulk({7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00,
      7'h40, 7'h00, 7'h00, 7'h00, 7'h00, 7'h7f});
    wr(LDP_SEL_DIM_CONFIG, 4'h0, 16'h0007);
    settle();
    check({4'h0, output_channel & 12'hfdf}, 16'h0001);
    high_time(5, LDP_PER3 * LDP_TICK_CYCLES, hi);
    exp = $rtoi(LDP_PER3 * $rtoi(64 * 65536.0 / 127 + 0.5) / 65536.0 + 0.5) * LDP_TICK_CYCLES;
    check(near(hi, exp), 16'(exp));
    wr(LDP_SEL_DIM_CONFIG, 4'h0, 16'h0002);
    settle();
    high_time(5, LDP_PER2 * LDP_TICK_CYCLES, hi);
    exp = $rtoi(LDP_PER2 * 0.9471 ** 63 + 0.5) * LDP_TICK_CYCLES;
    check(near(hi, exp), 16'(exp));
    wr(LDP_SEL_COMMON_LEVEL, 4'h0, 16'h007f);
    settle();
    check({4'h0, output_channel}, 16'h0fff);
    $display("duty test done");
  endtask : t_duty
  // Reset, then the scenarios in turn.
  initial begin
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    t_fault();
    t_full();
    t_duty();
    end_of_test();
  end
endmodule : tb
bind ldp_dimming_pwm ldp_assertions ldp_assertions_inst (.clock(clock), .rstn(rstn),
  .wr_strobe(wr_strobe), .wr_req(wr_req), .fault_rd_strobe(fault_rd_strobe),
  .open_load_in(open_load_in), .fault_rdata(fault_rdata), .fault_rvalid(fault_rvalid),
  .output_channel(output_channel));
